// >>> design/amss_pkg.sv
// constants, register map and state codes of the async memory strobe sequencer
// assumes one core clock; all phase counts are in core clock cycles
package amss_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_HZ           = 25_000_000;
  localparam int SYNC_STAGES      = 2;
  localparam int STALL_UNIT_CYC   = 16;
  localparam int STALL_EXIT_CYC   = 4;
  localparam int STALL_DECIDE_CYC = 1;
  localparam int RELEASE_CYC      = STALL_EXIT_CYC - SYNC_STAGES - STALL_DECIDE_CYC;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_ASYNC_CFG = 8'h00;
  localparam logic [7:0] OFS_WAIT_CFG  = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;

  // ==========================================================================
  // field layout of the asynchronous configuration register
  localparam int RS_LSB  = 0;
  localparam int RS_W    = 4;
  localparam int RST_LSB = 4;
  localparam int RST_W   = 6;
  localparam int RH_LSB  = 10;
  localparam int RH_W    = 3;
  localparam int WS_LSB  = 13;
  localparam int WS_W    = 4;
  localparam int WST_LSB = 17;
  localparam int WST_W   = 6;
  localparam int WH_LSB  = 23;
  localparam int WH_W    = 3;
  localparam int TA_LSB  = 26;
  localparam int TA_W    = 2;
  localparam int SS_BIT  = 28;
  localparam int EW_BIT  = 29;
  localparam int CFG_USED_W = 30;
  // wait-cycle configuration and status layout
  localparam int STALL_TIMEOUT_LIMIT_LSB  = 0;
  localparam int STALL_TIMEOUT_LIMIT_W    = 8;
  localparam int STS_BUSY  = 0;
  localparam int STS_TOUT  = 1;
  localparam int STS_EWC_LSB = 8;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_TOUT  = 1;
  localparam int IRQ_W     = 2;

  // ==========================================================================
  // reset values and response codes
  localparam logic [31:0] ASYNC_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] WAIT_CFG_RST  = 32'h0000_0080;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ==========================================================================
  // sequencer states
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_SETUP   = 7'h02,
    ST_STROBE  = 7'h04,
    ST_STALL   = 7'h08,
    ST_RELEASE = 7'h10,
    ST_HOLD    = 7'h20,
    ST_GAP     = 7'h40
  } amss_state_type;

endpackage : amss_pkg

// >>> design/amss_stall_if.sv
// bundle between the sequencer and its stall cycle counter
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface amss_stall_if;
  logic       clear;
  logic       counting;
  logic [7:0] limit;
  logic [7:0] count;
  logic       timed_out;
  modport ctr (input clear, input counting, input limit, output count, output timed_out);
  modport seq (output clear, output counting, output limit, input count, input timed_out);
endinterface : amss_stall_if

// >>> design/amss_sync.sv
// two-stage synchroniser for pin inputs
// assumes d changes asynchronously to clk
`timescale 1ns/1ps
module amss_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : amss_sync

// >>> design/amss_stall_ctr.sv
// counts stalled cycles in units of sixteen and flags the timeout limit
// assumes counting is high only while the strobe is stretched
`timescale 1ns/1ps
module amss_stall_ctr
  import amss_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   srst,
  amss_stall_if.ctr   sif
);
  logic [3:0] pre_q;
  logic [7:0] count_q;
  logic [7:0] count_d;

  // next count, so the limit ends the strobe on the cycle that reaches it
  always_comb begin
    count_d = count_q;
    if (sif.counting && pre_q == 4'(STALL_UNIT_CYC - 1) && count_q != 8'hFF) begin
      count_d = count_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || sif.clear) begin
      pre_q   <= 4'h0;
      count_q <= 8'h00;
    end else if (sif.counting) begin
      pre_q   <= pre_q + 4'h1;
      count_q <= count_d;
    end
  end

  assign sif.count = count_d;
  assign sif.timed_out = (sif.limit != 8'h00) && (count_d >= sif.limit);
endmodule : amss_stall_ctr

// >>> design/amss_top.sv
// async memory strobe sequencer with AXI4-Lite registers and one interrupt
// assumes clk is the core clock; mem_data_in and ext_stall_in are async pins
`timescale 1ns/1ps

module amss_top
  import amss_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [20:0] req_addr,
  input  wire logic [1:0]  req_bank,
  input  wire logic [15:0] req_wdata,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             rsp_timeout,
  output logic             irq,
  output logic [20:0]      mem_addr_out,
  output logic [1:0]       mem_bank_out,
  output logic             mem_select_n,
  output logic             mem_read_strobe_n,
  output logic             mem_write_strobe_n,
  output logic [15:0]      mem_data_out,
  output logic             mem_data_oe_n,
  input  wire logic [15:0] mem_data_in,
  input  wire logic        ext_stall_in
);

  // ==========================================================================
  // helpers
  function automatic logic [7:0] phase_load(input logic [7:0] len);
    phase_load = (len == 8'h00) ? 8'h00 : len - 8'h01;
  endfunction : phase_load

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    apply_strb = res;
  endfunction : apply_strb

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_ASYNC_CFG) || (a == OFS_WAIT_CFG) || (a == OFS_STATUS) ||
                (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
  endfunction : is_mapped

  // ==========================================================================
  // declarations
  amss_state_type state_q;
  amss_state_type state_d;
  logic [7:0]     cnt_q;
  logic [7:0]     cnt_d;
  logic           is_wr_q;
  logic           is_wr_d;
  logic           accept;
  logic           done_d;
  logic           tout_d;
  logic           strobe_low_d;
  logic           in_access_d;
  logic           stall_s;
  logic [15:0]    data_s;
  logic [31:0]    cfg_q;
  logic [31:0]    wait_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] stat_d;
  logic [IRQ_W-1:0] mask_q;
  logic [7:0]     last_ewc_q;
  logic           last_tout_q;
  logic [7:0]     rs_len;
  logic [7:0]     rst_len;
  logic [7:0]     rh_len;
  logic [7:0]     ws_len;
  logic [7:0]     wst_len;
  logic [7:0]     wh_len;
  logic [7:0]     ta_len;
  logic           ss_mode;
  logic           ew_en;
  logic           aw_full_q;
  logic           w_full_q;
  logic [7:0]     aw_addr_q;
  logic [31:0]    wdata_q;
  logic [3:0]     wstrb_q;
  logic           reg_wr;
  logic [31:0]    rd_word;

  amss_stall_if sif ();

  // ==========================================================================
  // pin synchronisers and stall counter
  amss_sync #(.W(1)) u_stall_sync (
    .clk  (clk),
    .srst (srst),
    .d    (ext_stall_in),
    .q    (stall_s)
  );

  amss_sync #(.W(16)) u_data_sync (
    .clk  (clk),
    .srst (srst),
    .d    (mem_data_in),
    .q    (data_s)
  );

  amss_stall_ctr u_stall_ctr (
    .clk  (clk),
    .srst (srst),
    .sif  (sif)
  );

  assign sif.clear    = accept;
  assign sif.counting = (state_q == ST_STALL);
  assign sif.limit    = wait_q[STALL_TIMEOUT_LIMIT_LSB +: STALL_TIMEOUT_LIMIT_W];

  // ==========================================================================
  // configuration fields
  // phase counts from software
  assign rs_len  = 8'(cfg_q[RS_LSB +: RS_W]);
  assign rst_len = 8'(cfg_q[RST_LSB +: RST_W]);
  assign rh_len  = 8'(cfg_q[RH_LSB +: RH_W]);
  assign ws_len  = 8'(cfg_q[WS_LSB +: WS_W]);
  assign wst_len = 8'(cfg_q[WST_LSB +: WST_W]);
  assign wh_len  = 8'(cfg_q[WH_LSB +: WH_W]);
  assign ta_len  = 8'(cfg_q[TA_LSB +: TA_W]);
  assign ss_mode = cfg_q[SS_BIT];
  assign ew_en   = cfg_q[EW_BIT];

  assign accept  = req_valid && req_ready && (state_q == ST_IDLE);
  assign is_wr_d = accept ? req_write : is_wr_q;

  // ==========================================================================
  // phase sequencer
  // setup, strobe, hold, gap order
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q - 8'h01;
    done_d  = 1'b0;
    tout_d  = 1'b0;
    case (state_q)
      ST_IDLE: begin
        cnt_d = 8'h00;
        if (accept) begin
          state_d = ST_SETUP;
          cnt_d   = phase_load(req_write ? ws_len : rs_len);
        end
      end
      ST_SETUP: begin
        if (cnt_q == 8'h00) begin
          state_d = ST_STROBE;
          cnt_d   = phase_load(is_wr_q ? wst_len : rst_len);
        end
      end
      ST_STROBE: begin
        if (cnt_q == 8'h00) begin
          if (ew_en && stall_s) begin
            state_d = ST_STALL;
            cnt_d   = 8'h00;
          end else begin
            state_d = ST_HOLD;
            cnt_d   = phase_load(is_wr_q ? wh_len : rh_len);
          end
        end
      end
      ST_STALL: begin
        cnt_d = 8'h00;
        if (sif.timed_out) begin
          state_d = ST_HOLD;
          tout_d  = 1'b1;
          cnt_d   = phase_load(is_wr_q ? wh_len : rh_len);
        end else if (!stall_s) begin
          state_d = ST_RELEASE;
          cnt_d   = 8'(RELEASE_CYC - 1);
        end
      end
      ST_RELEASE: begin
        if (cnt_q == 8'h00) begin
          state_d = ST_HOLD;
          cnt_d   = phase_load(is_wr_q ? wh_len : rh_len);
        end
      end
      ST_HOLD: begin
        if (cnt_q == 8'h00) begin
          done_d = 1'b1;
          if (ta_len != 8'h00) begin
            state_d = ST_GAP;
            cnt_d   = phase_load(ta_len);
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        if (cnt_q == 8'h00) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 8'h00;
      is_wr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      is_wr_q <= is_wr_d;
    end
  end

  // ==========================================================================
  // memory pins
  assign strobe_low_d = (state_d == ST_STROBE) || (state_d == ST_STALL) ||
                        (state_d == ST_RELEASE);
  assign in_access_d  = strobe_low_d || (state_d == ST_SETUP) || (state_d == ST_HOLD);

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_read_strobe_n  <= 1'b1;
      mem_write_strobe_n <= 1'b1;
      mem_select_n       <= 1'b1;
      mem_data_oe_n      <= 1'b1;
    end else begin
      // strobes low only in strobe, stall and release states
      mem_read_strobe_n  <= !(strobe_low_d && !is_wr_d);
      mem_write_strobe_n <= !(strobe_low_d && is_wr_d);
      mem_select_n       <= !(ss_mode ? strobe_low_d : in_access_d);
      mem_data_oe_n      <= !(in_access_d && is_wr_d);
    end
  end

  // address held from accept past hold
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_addr_out <= 21'h00_0000;
      mem_bank_out <= 2'h0;
      mem_data_out <= 16'h0000;
    end else if (accept) begin
      mem_addr_out <= req_addr;
      mem_bank_out <= req_bank;
      mem_data_out <= req_wdata;
    end
  end

  // ==========================================================================
  // request and response
  always_ff @(posedge clk) begin
    if (srst) begin
      req_ready   <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_rdata   <= 16'h0000;
      rsp_timeout <= 1'b0;
      last_ewc_q  <= 8'h00;
      last_tout_q <= 1'b0;
    end else begin
      req_ready <= (state_d == ST_IDLE) && !accept;
      rsp_valid <= done_d;
      if (!is_wr_q && state_q != ST_HOLD && state_d == ST_HOLD) begin
        rsp_rdata <= data_s;
      end
      if (state_q != ST_HOLD && state_d == ST_HOLD) begin
        rsp_timeout <= tout_d;
        last_tout_q <= tout_d;
        last_ewc_q  <= sif.count;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  assign reg_wr = aw_full_q && w_full_q && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (reg_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q  <= ASYNC_CFG_RST;
      wait_q <= WAIT_CFG_RST;
      mask_q <= '0;
    end else if (reg_wr) begin
      if (aw_addr_q == OFS_ASYNC_CFG) begin
        cfg_q <= apply_strb(cfg_q, wdata_q, wstrb_q) & 32'((64'h1 << CFG_USED_W) - 64'h1);
      end
      if (aw_addr_q == OFS_WAIT_CFG) begin
        wait_q <= apply_strb(wait_q, wdata_q, wstrb_q) & 32'h0000_00FF;
      end
      if (aw_addr_q == OFS_IRQ_MASK && wstrb_q[0]) begin
        mask_q <= wdata_q[IRQ_W-1:0];
      end
    end
  end

  // ==========================================================================
  // interrupt status, set wins over write-one-to-clear
  always_comb begin
    stat_d = stat_q;
    if (reg_wr && aw_addr_q == OFS_IRQ_STAT && wstrb_q[0]) begin
      stat_d = stat_q & ~wdata_q[IRQ_W-1:0];
    end
    if (done_d) begin
      stat_d[IRQ_DONE] = 1'b1;
    end
    if (tout_d) begin
      stat_d[IRQ_TOUT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stat_q <= '0;
      irq    <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq    <= |(stat_d & mask_q);
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      OFS_ASYNC_CFG: rd_word = cfg_q;
      OFS_WAIT_CFG:  rd_word = wait_q;
      OFS_STATUS: begin
        rd_word[STS_BUSY]                = (state_q != ST_IDLE);
        rd_word[STS_TOUT]                = last_tout_q;
        rd_word[STS_EWC_LSB +: 8]        = last_ewc_q;
      end
      OFS_IRQ_STAT:  rd_word[IRQ_W-1:0] = stat_q;
      OFS_IRQ_MASK:  rd_word[IRQ_W-1:0] = mask_q;
      default:       rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : amss_top

// >>> verif/amss_props.sv
// pin and handshake assertions of the sequencer
// assumes a bind to amss_top with names matching its ports
`timescale 1ns/1ps
module amss_props (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [20:0] mem_addr_out,
  input wire logic [1:0]  mem_bank_out,
  input wire logic        mem_select_n,
  input wire logic        mem_read_strobe_n,
  input wire logic        mem_write_strobe_n,
  input wire logic [15:0] mem_data_out,
  input wire logic        mem_data_oe_n
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);
  wire strb = !(mem_read_strobe_n && mem_write_strobe_n);
  // ==========
  // strobe shape
  a_one_strobe: assert property (mem_read_strobe_n || mem_write_strobe_n)
    else $error("both strobes low");
  a_sel_span: assert property (strb |-> !mem_select_n)
    else $error("strobe outside select");
  a_addr_held: assert property (
    strb |=> $stable(mem_addr_out) && $stable(mem_bank_out))
    else $error("address moved near strobe");
  a_wdata_held: assert property (
    !mem_write_strobe_n |=> !mem_data_oe_n && $stable(mem_data_out))
    else $error("write data not held");
  a_read_float: assert property (!mem_read_strobe_n |-> mem_data_oe_n)
    else $error("data driven during read");
  // ==========
  // phase order
  a_hold_after: assert property (
    $rose(mem_read_strobe_n) || $rose(mem_write_strobe_n) |-> !rsp_valid && !req_ready)
    else $error("hold phase skipped");
  a_busy_run: assert property (req_valid && req_ready |=> !req_ready [*3])
    else $error("ready during access");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  c_read: cover property ($fell(mem_read_strobe_n));
  c_write: cover property ($fell(mem_write_strobe_n));
  c_done: cover property (rsp_valid);
endmodule : amss_props

// >>> verif/amss_mem_model.sv
// behavioural asynchronous memory with a stall output
// assumes one access at a time on the sequencer clock
`timescale 1ns/1ps
module amss_mem_model (
  input  wire logic        clk,
  input  wire logic [20:0] mem_addr_out,
  input  wire logic [1:0]  mem_bank_out,
  input  wire logic        mem_select_n,
  input  wire logic        mem_read_strobe_n,
  input  wire logic        mem_write_strobe_n,
  input  wire logic [15:0] mem_data_out,
  input  wire logic        mem_data_oe_n,
  input  wire logic [15:0] stall_len,
  output logic      [15:0] mem_data_in,
  output logic             ext_stall_in
);
  logic [15:0] mem_q [64];
  logic [15:0] last_q = '0;
  logic [15:0] left_q = '0;
  logic        act_q = 1'b0;
  wire  [5:0]  key = {mem_bank_out, mem_addr_out[3:0]};
  wire         rd = !mem_select_n && !mem_read_strobe_n;
  wire         act = !(mem_read_strobe_n && mem_write_strobe_n);
  // released bus shows the inverse of the last word
  assign mem_data_in = rd ? mem_q[key] : ~last_q;
  assign ext_stall_in = left_q != 16'h0;
  always @(posedge clk) begin
    act_q <= act;
    if (rd) last_q <= mem_q[key];
    if (!mem_select_n && !mem_write_strobe_n && !mem_data_oe_n) mem_q[key] <= mem_data_out;
    if (left_q != 16'h0) left_q <= left_q - 16'h1;
    else if (act && !act_q) left_q <= stall_len;
  end
endmodule : amss_mem_model

// >>> verif/amss_top_tb.sv
// self-checking bench of the async memory strobe sequencer
// assumes design, memory model and checker compiled first
`timescale 1ns/1ps
module amss_top_tb;
  import amss_pkg::*;
  logic        clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, req_valid, req_write, req_ready, rsp_valid, rsp_timeout;
  logic        irq, mem_select_n, mem_read_strobe_n, mem_write_strobe_n, oe_sf;
  logic        mem_data_oe_n, ext_stall_in, to, p_str, p_sel, p_rdy, p_stl;
  logic [1:0]  s_axi_bresp, s_axi_rresp, req_bank, mem_bank_out, bk;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [15:0] req_wdata, rsp_rdata, mem_data_out, mem_data_in, stall_len, wd, d_sf, d_rsp;
  logic [15:0] shadow [64];
  logic [20:0] req_addr, mem_addr_out, ad, a_sf;
  logic [22:0] a_rsp;
  logic [31:0] s_axi_wdata, s_axi_rdata, rng_q, r;
  int          bad_count, n_checks, cyc, rs, rst, rh, ta, ss, ew;
  int          t_acc, t_sf, t_sr, t_self, t_selr, t_rsp, t_rdy, t_stl;
  wire         str_n = mem_read_strobe_n & mem_write_strobe_n;
  amss_top uut (.*);
  amss_mem_model mem (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  function automatic logic [31:0] rnd();
    rng_q ^= rng_q << 13;
    rng_q ^= rng_q >> 17;
    rng_q ^= rng_q << 5;
    return rng_q;
  endfunction : rnd
  // ==========
  // register bus
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n++ < 50);
    chk(n > 50, 0);
    chk(s_axi_bresp, er);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                        input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n++ < 50);
    chk(n > 50, 0);
    chk(s_axi_rdata & m, d);
    chk(s_axi_rresp, er);
  endtask : axi_rd
  // ==========
  // pin monitor, times as seen one edge late
  always @(posedge clk) begin
    cyc++;
    if (req_valid && req_ready) t_acc = cyc + 1;
    if (p_str && !str_n) begin
      t_sf = cyc;
      a_sf = mem_addr_out;
      d_sf = mem_data_out;
      oe_sf = mem_data_oe_n;
    end
    if (!p_str && str_n) t_sr = cyc;
    if (p_sel && !mem_select_n) t_self = cyc;
    if (!p_sel && mem_select_n) t_selr = cyc;
    if (rsp_valid) begin
      t_rsp = cyc;
      a_rsp = {mem_bank_out, mem_addr_out};
      d_rsp = mem_data_out;
    end
    if (!p_rdy && req_ready) t_rdy = cyc;
    if (p_stl && !ext_stall_in) t_stl = cyc;
    p_str = str_n;
    p_sel = mem_select_n;
    p_rdy = req_ready;
    p_stl = ext_stall_in;
  end
  // active direction gets the drawn lengths, the other fixed ones
  function automatic logic [31:0] cfg_word(input logic wr);
    logic [31:0] v;
    v = ta << TA_LSB | ss << SS_BIT | ew << EW_BIT;
    v |= (wr ? 2 : rs) << RS_LSB | (wr ? 4 : rst) << RST_LSB | (wr ? 2 : rh) << RH_LSB;
    v |= (wr ? rs : 2) << WS_LSB | (wr ? rst : 4) << WST_LSB | (wr ? rh : 2) << WH_LSB;
    return v;
  endfunction : cfg_word
  task automatic run(input logic wr);
    int n;
    int k;
    n = 0;
    k = {bk, ad[3:0]};
    axi_wr(OFS_ASYNC_CFG, cfg_word(wr), RESP_OKAY);
    req_write <= wr;
    req_addr <= ad;
    req_bank <= bk;
    req_wdata <= wd;
    req_valid <= 1'b1;
    do @(posedge clk); while (!req_ready && n++ < 40);
    req_valid <= 1'b0;
    chk(n > 40, 0);
    n = 0;
    do @(posedge clk); while (!rsp_valid && n++ < 900);
    chk(n > 900, 0);
    repeat (ta + 2) @(posedge clk);
    chk(t_sf - t_acc, rs);
    chk(a_sf, ad);
    chk(t_sf - t_self, ss ? 0 : rs);
    chk(t_selr - t_sr, ss ? 0 : rh);
    chk(t_rsp - t_sr, rh);
    chk(a_rsp, {bk, ad});
    chk(t_rdy - t_rsp, ta);
    chk(rsp_timeout, to);
    if (!ew) chk(t_sr - t_sf, rst);
    else if (to) chk(t_sr - t_sf, rst + 2 * STALL_UNIT_CYC);
    else chk(t_sr - t_stl, STALL_EXIT_CYC);
    if (wr) begin
      chk(d_sf, wd);
      chk(d_rsp, wd);
      chk(oe_sf, 1'b0);
      shadow[k] = wd;
    end else chk(rsp_rdata, shadow[k]);
  endtask : run
  // ==========
  // main sequence
  initial begin
    rng_q = 32'h6382F3CF;
    {srst, p_str, p_sel, p_stl, s_axi_wstrb} = 8'hFF;
    {p_rdy, to, ew, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, req_valid, req_write, req_addr, req_bank, req_wdata} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, stall_len} = '0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    axi_rd(OFS_ASYNC_CFG, ASYNC_CFG_RST, 32'hFFFFFFFF, RESP_OKAY);
    axi_rd(OFS_WAIT_CFG, WAIT_CFG_RST, 32'hFFFFFFFF, RESP_OKAY);
    axi_wr(8'h20, 32'h1, RESP_SLVERR);
    axi_rd(8'h20, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    axi_wr(OFS_WAIT_CFG, 32'h0, RESP_OKAY);
    for (int i = 0; i < 24; i++) begin
      rs = 1 + rnd() % 15;
      rst = 3 + rnd() % 61;
      rh = 1 + rnd() % 7;
      ta = 1 + rnd() % 3;
      ss = rnd() % 2;
      r = rnd();
      if (i % 2 == 0) {wd, bk, ad[20:7]} = r;
      if (i % 2 == 0) ad[6:0] = rnd() % 128;
      run(i % 2 == 0);
    end
    ew = 1;
    rst = 6;
    stall_len <= 16'h0028;
    run(1'b1);
    run(1'b0);
    axi_wr(OFS_WAIT_CFG, 32'h2, RESP_OKAY);
    to = 1'b1;
    stall_len <= 16'h012C;
    run(1'b0);
    stall_len <= 16'h0000;
    repeat (300) @(posedge clk);
    axi_rd(OFS_STATUS, 32'h00000202, 32'h0000FF02, RESP_OKAY);
    chk(irq, 1'b0);
    axi_wr(OFS_IRQ_MASK, 32'h3, RESP_OKAY);
    @(posedge clk);
    chk(irq, 1'b1);
    axi_rd(OFS_IRQ_STAT, 32'h3, 32'h3, RESP_OKAY);
    axi_wr(OFS_IRQ_STAT, 32'h3, RESP_OKAY);
    @(posedge clk);
    chk(irq, 1'b0);
    close_out();
  end
  // about 2000 cycles expected; fifteen times that is a hang
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule : amss_top_tb
bind amss_top amss_props chk (.*);
